// file: rtl/ext_cap_map.vh
`ifndef EXT_CAP_MAP_VH
`define EXT_CAP_MAP_VH
// ****************************************
// register byte addresses
// ****************************************
`define OFS_ERR_CTL 12'h118
`define OFS_HDR_DW1 12'h11C
`define OFS_HDR_DW2 12'h120
`define OFS_HDR_DW3 12'h124
`define OFS_HDR_DW4 12'h128
`define OFS_SER_HDR 12'h180
`define OFS_SER_LOW 12'h184
`define OFS_SER_HIGH 12'h188
`define OFS_VC_HDR 12'h200
`define OFS_VC_CAP1 12'h204
// ****************************************
// capability header fields
// ****************************************
`define CAP_ID_LSB 0
`define CAP_VER_LSB 16
`define CAP_NEXT_LSB 20
`define SER_CAP_ID 16'h0003
`define VC_CAP_ID 16'h0002
`define CAP_VERSION 4'h1
`define CAP_NEXT_END 12'h000
// ****************************************
// port vc capability one fields
// ****************************************
`define EXTRA_CNT_LSB 0
`define LP_EXTRA_CNT_LSB 4
`define ARB_TIME_LSB 8
`define ARB_SIZE_LSB 10
`define EXTRA_CNT_RST 3'h0
`define LP_EXTRA_CNT_RST 3'h0
`define ARB_TIME_VAL 2'h0
`define ARB_SIZE_RST 2'h2
// ****************************************
// reset values
// ****************************************
`define WORD_RST 32'h0000_0000
`define ERR_IDX_RST 5'h00
`endif

// file: rtl/pcie_ext_cap_regs.v
// Contract
// - sticky log of third header doubleword
// - sticky log of fourth header doubleword
// - serial header capability id reads 3
// - serial header version reads 1
// - twelve-bit next offset, zero ends chain
// - serial low word, default zero
// - serial high word, default zero
// - vc header capability id reads 2
// - vc header version reads 1
// - extra channel count defaults zero
// - low-priority extra count defaults zero
// - arbitration time base always zero
// - arbitration entry size defaults 2
// - first and second header words sticky
// - first error index valid while bit set
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ext_cap_map.vh"
module pcie_ext_cap_regs #(
  parameter [11:0] SER_NEXT_RST = `CAP_NEXT_END,
  parameter [11:0] VC_NEXT_RST = `CAP_NEXT_END
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire soft_reset_in,
  input wire config_unlock_in,
  input wire [11:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [3:0] byteenable_in,
  input wire [31:0] writedata_in,
  output wire waitrequest_out,
  output wire [31:0] readdata_out,
  input wire err_capture_in,
  input wire [4:0] err_index_in,
  input wire [31:0] err_hdr_dw1_in,
  input wire [31:0] err_hdr_dw2_in,
  input wire [31:0] err_hdr_dw3_in,
  input wire [31:0] err_hdr_dw4_in,
  input wire [31:0] err_status_in,
  output wire first_error_valid_out,
  output wire [4:0] first_error_index_out,
  output wire [63:0] serial_number_out
);

  // ****************************************
  // bus handshake
  // ****************************************
  reg ack_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire req = read_in | write_in;
  wire wr_now = write_in & ack_q;
  wire lock_wr = wr_now & config_unlock_in;
  // one wait cycle keeps read data registered
  assign waitrequest_out = req & ~ack_q;
  assign readdata_out = rdata_q;

  // ****************************************
  // storage
  // ****************************************
  reg [31:0] hdr_q [0:3];
  reg [4:0] err_idx_q;
  reg logged_q;
  reg [31:0] ser_low_q;
  reg [31:0] ser_high_q;
  reg [11:0] ser_next_q;
  reg [11:0] vc_next_q;
  reg [2:0] extra_cnt_q;
  reg [2:0] lp_extra_cnt_q;
  reg [1:0] arb_size_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  wire [31:0] wmerge_ser_hdr = merge({ser_next_q, 20'h0_0000}, writedata_in, byteenable_in);
  wire [31:0] wmerge_vc_hdr = merge({vc_next_q, 20'h0_0000}, writedata_in, byteenable_in);
  wire [31:0] vc_cap1_word = {20'h0_0000, arb_size_q, `ARB_TIME_VAL, 1'b0,
                              lp_extra_cnt_q, 1'b0, extra_cnt_q};
  wire [31:0] wmerge_vc_cap1 = merge(vc_cap1_word, writedata_in, byteenable_in);

  // ****************************************
  // header log, sticky
  // ****************************************
  // index valid while bit set
  wire idx_bit_set = err_status_in[err_idx_q];
  wire take_err = err_capture_in & ~logged_q;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : hdr_gen
      wire [31:0] cap_word = (g == 0) ? err_hdr_dw1_in : (g == 1) ? err_hdr_dw2_in :
                             (g == 2) ? err_hdr_dw3_in : err_hdr_dw4_in;
      wire [31:0] ofs_full = `OFS_HDR_DW1 + (g * 4);
      wire [11:0] ofs = ofs_full[11:0];
      always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          hdr_q[g] <= `WORD_RST;
        end else if (take_err) begin
          hdr_q[g] <= cap_word;
        end else if (lock_wr && address_in == ofs) begin
          hdr_q[g] <= merge(hdr_q[g], writedata_in, byteenable_in);
        end
      end
    end
  endgenerate

  // release of the log beats a new capture in the same cycle; capture is taken only while the log is empty
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_idx_q <= `ERR_IDX_RST;
      logged_q <= 1'b0;
    end else if (take_err) begin
      err_idx_q <= err_index_in;
      logged_q <= 1'b1;
    end else if (logged_q && !idx_bit_set) begin
      logged_q <= 1'b0;
    end
  end

  assign first_error_valid_out = logged_q & idx_bit_set;
  assign first_error_index_out = err_idx_q;

  // ****************************************
  // lockable capability fields
  // ****************************************
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ser_low_q <= `WORD_RST;
      ser_high_q <= `WORD_RST;
      ser_next_q <= SER_NEXT_RST;
      vc_next_q <= VC_NEXT_RST;
      extra_cnt_q <= `EXTRA_CNT_RST;
      lp_extra_cnt_q <= `LP_EXTRA_CNT_RST;
      arb_size_q <= `ARB_SIZE_RST;
    end else if (soft_reset_in) begin
      ser_low_q <= `WORD_RST;
      ser_high_q <= `WORD_RST;
      ser_next_q <= SER_NEXT_RST;
      vc_next_q <= VC_NEXT_RST;
      extra_cnt_q <= `EXTRA_CNT_RST;
      lp_extra_cnt_q <= `LP_EXTRA_CNT_RST;
      arb_size_q <= `ARB_SIZE_RST;
    end else if (lock_wr) begin
      if (address_in == `OFS_SER_LOW) begin
        ser_low_q <= merge(ser_low_q, writedata_in, byteenable_in);
      end else if (address_in == `OFS_SER_HIGH) begin
        ser_high_q <= merge(ser_high_q, writedata_in, byteenable_in);
      end else if (address_in == `OFS_SER_HDR) begin
        ser_next_q <= wmerge_ser_hdr[31:20];
      end else if (address_in == `OFS_VC_HDR) begin
        vc_next_q <= wmerge_vc_hdr[31:20];
      end else if (address_in == `OFS_VC_CAP1) begin
        extra_cnt_q <= wmerge_vc_cap1[2:0];
        lp_extra_cnt_q <= wmerge_vc_cap1[6:4];
        arb_size_q <= wmerge_vc_cap1[11:10];
      end
    end
  end

  assign serial_number_out = {ser_high_q, ser_low_q};

  // ****************************************
  // read decode
  // ****************************************
  always @* begin
    rdata_d = `WORD_RST;
    if (address_in == `OFS_ERR_CTL) begin
      rdata_d = {27'h000_0000, err_idx_q};
    end else if (address_in == `OFS_HDR_DW1) begin
      rdata_d = hdr_q[0];
    end else if (address_in == `OFS_HDR_DW2) begin
      rdata_d = hdr_q[1];
    end else if (address_in == `OFS_HDR_DW3) begin
      rdata_d = hdr_q[2];
    end else if (address_in == `OFS_HDR_DW4) begin
      rdata_d = hdr_q[3];
    end else if (address_in == `OFS_SER_HDR) begin
      rdata_d = {ser_next_q, `CAP_VERSION, `SER_CAP_ID};
    end else if (address_in == `OFS_SER_LOW) begin
      rdata_d = ser_low_q;
    end else if (address_in == `OFS_SER_HIGH) begin
      rdata_d = ser_high_q;
    end else if (address_in == `OFS_VC_HDR) begin
      rdata_d = {vc_next_q, `CAP_VERSION, `VC_CAP_ID};
    end else if (address_in == `OFS_VC_CAP1) begin
      rdata_d = vc_cap1_word;
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      rdata_q <= `WORD_RST;
    end else begin
      ack_q <= req & ~ack_q;
      if (read_in && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/ext_cap_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ext_cap_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic config_unlock_in,
  input wire logic [11:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  input wire logic waitrequest_out,
  input wire logic [31:0] readdata_out,
  input wire logic first_error_valid_out,
  input wire logic [4:0] first_error_index_out,
  input wire logic [63:0] serial_number_out
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_ok = read_in && !waitrequest_out;
  wire wr_ok = write_in && !waitrequest_out && !soft_reset_in;
  chk_ser_ident: assert property (rd_ok && address_in == 12'h180 |-> readdata_out[15:0] == 16'h0003)
    else $error("serial header id wrong");
  chk_ser_ver: assert property (rd_ok && address_in == 12'h180 |-> readdata_out[19:16] == 4'h1)
    else $error("serial header version wrong");
  chk_vc_ident: assert property (rd_ok && address_in == 12'h200 |-> readdata_out[15:0] == 16'h0002)
    else $error("vc header id wrong");
  chk_vc_ver: assert property (rd_ok && address_in == 12'h200 |-> readdata_out[19:16] == 4'h1)
    else $error("vc header version wrong");
  chk_resv_zero: assert property (rd_ok && address_in == 12'h204 |-> readdata_out[31:12] == 20'h0_0000
    && readdata_out[9:8] == 2'h0 && !readdata_out[3] && !readdata_out[7]) else $error("vc cap bits set");
  chk_index_hold: assert property (first_error_valid_out |=> $stable(first_error_index_out))
    else $error("first error index moved");
  chk_ser_load: assert property (wr_ok && config_unlock_in && address_in == 12'h184
    && byteenable_in == 4'hF |=> serial_number_out[31:0] == $past(writedata_in)) else $error("serial low");
  chk_lock_hold: assert property (wr_ok && !config_unlock_in |=> $stable(serial_number_out))
    else $error("locked write took effect");
  chk_soft_clear: assert property (soft_reset_in |=> serial_number_out == 64'h0)
    else $error("serial kept over soft reset");
endmodule
`default_nettype wire

// file: tb/pcie_ext_cap_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcie_ext_cap_regs_tb_top;
  logic clock_in = 0, rst_n_in = 0, soft_reset_in = 0, config_unlock_in = 0;
  logic read_in = 0, write_in = 0, err_capture_in = 0, waitrequest_out, first_error_valid_out;
  logic [11:0] address_in = 12'h000;
  logic [3:0] byteenable_in = 4'hF;
  logic [4:0] err_index_in = 5'h00, first_error_index_out;
  logic [31:0] writedata_in = 32'h0, err_status_in = 32'h0, readdata_out, q;
  logic [31:0] err_hdr_dw1_in = 32'h1111_0001, err_hdr_dw2_in = 32'h2222_0002;
  logic [31:0] err_hdr_dw3_in = 32'h3333_0003, err_hdr_dw4_in = 32'h4444_0004;
  logic [63:0] serial_number_out;
  int miscompares = 0, comparisons = 0;
  always #50 clock_in = ~clock_in;
  pcie_ext_cap_regs u_pcie_ext_cap_regs (.*);
  // ****************
  // tasks
  // ****************
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task acc(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_in);
    address_in <= a;
    read_in <= !w;
    write_in <= w;
    writedata_in <= d;
    do @(posedge clock_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    read_in <= 0;
    write_in <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    acc(a, 0, 32'h0);
    chk(q, e);
  endtask
  task wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1;
    rd(12'h124, 32'h0);
    rd(12'h128, 32'h0);
    rd(12'h180, 32'h0001_0003);
    rd(12'h184, 32'h0);
    rd(12'h188, 32'h0);
    rd(12'h200, 32'h0001_0002);
    rd(12'h204, 32'h0000_0800);
    rd(12'h300, 32'h0);
    acc(12'h184, 1, 32'hFFFF_FFFF);
    rd(12'h184, 32'h0);
    config_unlock_in <= 1;
    acc(12'h184, 1, 32'h1234_5678);
    acc(12'h188, 1, 32'h9ABC_DEF0);
    acc(12'h204, 1, 32'hFFFF_FFFF);
    acc(12'h180, 1, 32'hFFFF_FFFF);
    @(negedge clock_in);
    chk(serial_number_out, 64'h9ABC_DEF0_1234_5678);
    rd(12'h204, 32'h0000_0C77);
    rd(12'h180, 32'hFFF1_0003);
    err_index_in <= 5'h05;
    err_status_in <= 32'h0000_0020;
    err_capture_in <= 1;
    @(posedge clock_in);
    err_capture_in <= 0;
    @(posedge clock_in);
    // a later error must not overwrite the first log
    err_index_in <= 5'h06;
    err_hdr_dw3_in <= 32'h5555_0005;
    err_capture_in <= 1;
    @(posedge clock_in);
    err_capture_in <= 0;
    @(negedge clock_in);
    chk(first_error_valid_out, 1);
    chk(first_error_index_out, 5'h05);
    rd(12'h11C, 32'h1111_0001);
    rd(12'h124, 32'h3333_0003);
    rd(12'h128, 32'h4444_0004);
    soft_reset_in <= 1;
    @(posedge clock_in);
    soft_reset_in <= 0;
    @(negedge clock_in);
    chk(serial_number_out, 64'h0);
    rd(12'h124, 32'h3333_0003);
    err_status_in <= 32'h0;
    @(negedge clock_in);
    chk(first_error_valid_out, 0);
    wrap_up;
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
bind pcie_ext_cap_regs ext_cap_chk u_ext_cap_chk (.*);
`default_nettype wire
